/* core/pss_pkg.sv */
// What this block does
// - Three states only: awake, light sleep, deep sleep; halt command leaves awake.
// - Awake strobe clock divides the system clock to about 640 kHz, 600-650 kHz.
// - In either sleep state the strobe clock stops and sits high.
// - Timekeeping counter runs in every state; only reset clears it.
// - Divide the 32.768 kHz reference to a 512 Hz tick.
// - Keyboard entry, interrupt or due alarm always brings either sleep state back to awake.
// - Awake: processor, strobe, command/data line and bus active; display powered, driven.
// - In sleep the bus is precharged low, then held low through a weak pull.
// - In light sleep the wake timer wakes the processor after 0.5 s.
// - Light sleep ends on key or service request, or 10 minute idle forces deep sleep.
// - In deep sleep the display is unpowered and undriven, drive lines held high.
// - Wake timer maximum is four hours; deep sleep wakes at that interval, then reloads.
// - Deep sleep ends on internal interrupt; power key moves it to light sleep.
// - Module insert or removal pulses the interrupt line low briefly.
package pss_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int STROBE_HZ = 640_000;
  // Rounded to nearest: 8 cycles per half period gives 625 kHz
  localparam int STROBE_HALF = (CLK_HZ + STROBE_HZ) / (2 * STROBE_HZ);
  localparam int REF_HZ = 32_768;
  localparam int TICK_HZ = 512;
  localparam int REF_DIV = REF_HZ / TICK_HZ;
  localparam int HALF_SEC_MS = 500;
  localparam int IDLE_MIN = 10;
  localparam int MAX_HOURS = 4;
  localparam int HALF_TICKS = TICK_HZ * HALF_SEC_MS / 1000;
  localparam int IDLE_TICKS = IDLE_MIN * 60 * TICK_HZ;
  localparam int MAX_TICKS = MAX_HOURS * 3600 * TICK_HZ;
  localparam int TMR_W = 23;
  localparam int TIME_W = 32;
  localparam int PRECHARGE_CYCLES = 1;
  localparam int INT_PULSE_CYCLES = 4;
  localparam logic [3:0] BUS_LOW = 4'h0;

  typedef enum logic [1:0] {
    PSS_AWAKE = 2'h0,
    PSS_LIGHT = 2'h1,
    PSS_DEEP = 2'h2
  } pss_state_t;
endpackage

/* core/pss_div_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface pss_div_if;
  logic step;
  logic tick;
  modport src (output step, input tick);
  modport div (input step, output tick);
endinterface
`default_nettype wire

/* core/pss_divider.sv */
`timescale 1ns/1ns
`default_nettype none
module pss_divider #(
  parameter int N = 2
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic run_i,
  pss_div_if.div d
);
  logic [$clog2(N+1)-1:0] count;

  // Restarts whenever run drops, so each run begins with a full period
  always_ff @(posedge clock_i) begin
    if (!resetn_i || !run_i) begin
      count <= '0;
    end else if (d.step) begin
      if (count == ($clog2(N+1))'(N - 1)) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  assign d.tick = run_i && d.step && (count == ($clog2(N+1))'(N - 1));
endmodule
`default_nettype wire

/* core/pss_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int HALF_T = HALF_TICKS,
  parameter int IDLE_T = IDLE_TICKS,
  parameter int MAX_T = MAX_TICKS
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ref_clock_i,
  input wire logic halt_command_i,
  input wire logic key_entry_i,
  input wire logic power_key_i,
  input wire logic interrupt_i,
  input wire logic alarm_due_i,
  input wire logic module_change_i,
  input wire logic command_data_i,
  input wire logic [3:0] bus_data_i,
  output logic [1:0] state_o,
  output logic cpu_run_o,
  output logic bus_strobe_clock_o,
  output logic strobe_oe_o,
  output logic command_data_line_o,
  output logic command_data_oe_o,
  output logic [3:0] bus_o,
  output logic bus_oe_o,
  output logic bus_pull_low_o,
  output logic display_power_o,
  output logic display_drive_o,
  output logic display_lines_high_o,
  output logic tick512_o,
  output logic timer_wake_o,
  output logic interrupt_line_n_o,
  output logic [TIME_W-1:0] time_count_o
);
  pss_state_t state;
  pss_state_t next_state;
  pss_div_if strobe_div ();
  pss_div_if tick_div ();
  logic ref_prev;
  logic [TMR_W-1:0] wake_count;
  logic [TMR_W-1:0] idle_count;
  logic idle_expired;
  logic user_awake;
  logic timer_due;
  logic user_wake;
  logic [1:0] precharge;
  logic [2:0] int_count;

  assign strobe_div.step = 1'b1;
  assign tick_div.step = ref_clock_i && !ref_prev;
  assign user_wake = key_entry_i || interrupt_i || alarm_due_i || module_change_i;
  assign timer_due = tick_div.tick && (wake_count == TMR_W'(1));
  assign idle_expired = (idle_count == TMR_W'(IDLE_T));

  pss_divider #(.N(STROBE_HALF)) u_strobe_div (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .run_i(state == PSS_AWAKE),
    .d(strobe_div)
  );

  pss_divider #(.N(REF_DIV)) u_tick_div (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .run_i(1'b1),
    .d(tick_div)
  );

  always_comb begin
    next_state = state;
    case (state)
      PSS_AWAKE: begin
        if (halt_command_i) begin
          next_state = idle_expired ? PSS_DEEP : PSS_LIGHT;
        end
      end
      PSS_LIGHT: begin
        if (user_wake || timer_due) begin
          next_state = PSS_AWAKE;
        end else if (idle_expired) begin
          next_state = PSS_DEEP;
        end
      end
      PSS_DEEP: begin
        if (user_wake || timer_due) begin
          next_state = PSS_AWAKE;
        end else if (power_key_i) begin
          next_state = PSS_LIGHT;
        end
      end
      default: next_state = PSS_AWAKE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state <= PSS_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ref_prev <= 1'b0;
      tick512_o <= 1'b0;
      time_count_o <= '0;
    end else begin
      ref_prev <= ref_clock_i;
      if (tick_div.tick) begin
        tick512_o <= !tick512_o;
        time_count_o <= time_count_o + 1'b1;
      end
    end
  end

  // Wake timer: half second into light sleep, maximum into deep sleep
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wake_count <= '0;
    end else if (next_state == PSS_LIGHT && state != PSS_LIGHT) begin
      wake_count <= TMR_W'(HALF_T);
    end else if (next_state == PSS_DEEP && state != PSS_DEEP) begin
      wake_count <= TMR_W'(MAX_T);
    end else if (tick_div.tick && wake_count != '0) begin
      wake_count <= wake_count - 1'b1;
    end
  end

  // Idle time keeps running across cursor-blink wakes, not across user wakes
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      user_awake <= 1'b1;
      idle_count <= '0;
    end else if (user_wake || (state == PSS_DEEP && power_key_i)) begin
      user_awake <= 1'b1;
      idle_count <= '0;
    end else if (state == PSS_AWAKE && halt_command_i) begin
      user_awake <= 1'b0;
    end else if (tick_div.tick && !user_awake && !idle_expired) begin
      idle_count <= idle_count + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      timer_wake_o <= 1'b0;
    end else begin
      timer_wake_o <= timer_due && state != PSS_AWAKE && !user_wake;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      bus_strobe_clock_o <= 1'b1;
    end else if (next_state != PSS_AWAKE) begin
      bus_strobe_clock_o <= 1'b1;
    end else if (strobe_div.tick) begin
      bus_strobe_clock_o <= !bus_strobe_clock_o;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_o <= PSS_AWAKE;
      cpu_run_o <= 1'b1;
      strobe_oe_o <= 1'b1;
      command_data_line_o <= 1'b1;
      command_data_oe_o <= 1'b1;
      display_power_o <= 1'b1;
      display_drive_o <= 1'b1;
      display_lines_high_o <= 1'b0;
    end else begin
      state_o <= next_state;
      cpu_run_o <= next_state == PSS_AWAKE;
      // Sleep releases both lines; the weak pull-ups hold them high
      strobe_oe_o <= next_state == PSS_AWAKE;
      command_data_oe_o <= next_state == PSS_AWAKE;
      command_data_line_o <= next_state == PSS_AWAKE ? command_data_i : 1'b1;
      display_power_o <= next_state != PSS_DEEP;
      display_drive_o <= next_state != PSS_DEEP;
      display_lines_high_o <= next_state == PSS_DEEP;
    end
  end

  // Bus: driven low for the precharge, then released to the weak pull-down
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      precharge <= '0;
      bus_o <= BUS_LOW;
      bus_oe_o <= 1'b0;
      bus_pull_low_o <= 1'b0;
    end else if (next_state == PSS_AWAKE) begin
      precharge <= 2'(PRECHARGE_CYCLES);
      bus_o <= bus_data_i;
      bus_oe_o <= 1'b1;
      bus_pull_low_o <= 1'b0;
    end else begin
      bus_o <= BUS_LOW;
      bus_pull_low_o <= 1'b1;
      bus_oe_o <= precharge != '0;
      if (precharge != '0) begin
        precharge <= precharge - 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      int_count <= '0;
      interrupt_line_n_o <= 1'b1;
    end else if (module_change_i) begin
      int_count <= 3'(INT_PULSE_CYCLES - 1);
      interrupt_line_n_o <= 1'b0;
    end else if (int_count != '0) begin
      int_count <= int_count - 1'b1;
    end else begin
      interrupt_line_n_o <= 1'b1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence s_halt_in_awake;
    state == PSS_AWAKE && halt_command_i;
  endsequence
  sequence s_sleep_strobe;
    bus_strobe_clock_o && !strobe_oe_o && !cpu_run_o;
  endsequence

  a_halt_stops_strobe: assert property (s_halt_in_awake |=> s_sleep_strobe)
    else $error("strobe not parked high after halt");
  a_strobe_half_period: assert property ($rose(bus_strobe_clock_o) && state == PSS_AWAKE
      |=> bus_strobe_clock_o [*7] ##1 (!bus_strobe_clock_o || state != PSS_AWAKE))
    else $error("strobe half period not eight cycles");
  a_user_wakes_up: assert property (state != PSS_AWAKE && user_wake |=> state == PSS_AWAKE)
    else $error("wake request did not reach awake");
  a_power_key_light: assert property (state == PSS_DEEP && power_key_i && !user_wake && !timer_due
      |=> state == PSS_LIGHT)
    else $error("power key did not enter light sleep");
  a_deep_display_off: assert property (state == PSS_DEEP |=> !display_power_o && display_lines_high_o
      || state != PSS_DEEP)
    else $error("display active in deep sleep");
  a_bus_precharge_low: assert property (s_halt_in_awake |=> bus_oe_o && bus_o == BUS_LOW
      ##1 (!bus_oe_o && bus_pull_low_o) || state == PSS_AWAKE)
    else $error("bus not precharged then released");
  a_half_second_load: assert property ((s_halt_in_awake and !idle_expired)
      |=> state == PSS_LIGHT && wake_count == TMR_W'(HALF_T))
    else $error("light sleep timer not half second");
  a_deep_max_load: assert property ($rose(state == PSS_DEEP) |-> wake_count == TMR_W'(MAX_T))
    else $error("deep sleep timer not at maximum");
  a_idle_forces_deep: assert property (state == PSS_LIGHT && idle_expired && !user_wake && !timer_due
      |=> state == PSS_DEEP)
    else $error("idle timeout did not force deep sleep");
  a_module_int_pulse: assert property (module_change_i
      |=> !interrupt_line_n_o [*4] ##1 (interrupt_line_n_o || module_change_i))
    else $error("interrupt pulse width wrong");
  a_time_keeps_count: assert property (tick_div.tick |=> time_count_o == $past(time_count_o) + 1'b1)
    else $error("time counter missed a tick");
  a_state_legal: assert property (state == PSS_AWAKE || state == PSS_LIGHT || state == PSS_DEEP)
    else $error("illegal state code");
endmodule
`default_nettype wire

/* verification/pss_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pss_cpu_model #(
  parameter int REF_HALF = 2,
  parameter int BLINK = 3
) (
  input wire logic clock_i,
  input wire logic sleep_on_i,
  input wire logic cpu_run_i,
  output logic halt_o,
  output logic ref_clock_o
);
  int ref_cnt = 0;
  int run_cnt = 0;
  initial begin
    halt_o = 1'b0;
    ref_clock_o = 1'b0;
  end
  // Crystal runs free; period shortened to keep the run brief
  always @(negedge clock_i) begin
    ref_cnt = (ref_cnt + 1) % REF_HALF;
    if (ref_cnt == 0) begin
      ref_clock_o = ~ref_clock_o;
    end
  end
  // Software: blink or reload, then halt again; timer arming is done by the device
  always @(negedge clock_i) begin
    if (cpu_run_i === 1'b1 && sleep_on_i) begin
      run_cnt = run_cnt + 1;
    end else begin
      run_cnt = 0;
    end
    halt_o = (run_cnt == BLINK);
  end
endmodule
`default_nettype wire

/* verification/power_state_sequencer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module power_state_sequencer_tb;
  import pss_pkg::*;
  localparam int HT = 4;
  localparam int IT = 20;
  localparam int MT = 8;
  localparam int TC = 256;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ref_clock, halt;
  logic sleep_on = 1'b0;
  logic key = 1'b0, pkey = 1'b0, intr = 1'b0, alarm = 1'b0, modc = 1'b0, cd = 1'b0;
  logic [3:0] bus_d = 4'h0;
  logic [1:0] state;
  logic cpu_run, strobe, strobe_oe, cd_line, cd_oe, bus_oe, pull_low, d_pow, d_drv, d_high, tick, twake, int_n;
  logic [3:0] bus_q;
  logic [TIME_W-1:0] tcount, t0;
  logic [31:0] seed = 32'hE0CB;
  logic tw_seen;
  logic tick_prev;
  int n_fail = 0;
  int checks_done = 0;
  int n, i;

  pss_sequencer #(.HALF_T(HT), .IDLE_T(IT), .MAX_T(MT)) dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .ref_clock_i(ref_clock), .halt_command_i(halt), .key_entry_i(key), .power_key_i(pkey),
    .interrupt_i(intr), .alarm_due_i(alarm), .module_change_i(modc), .command_data_i(cd),
    .bus_data_i(bus_d), .state_o(state), .cpu_run_o(cpu_run), .bus_strobe_clock_o(strobe),
    .strobe_oe_o(strobe_oe), .command_data_line_o(cd_line), .command_data_oe_o(cd_oe), .bus_o(bus_q),
    .bus_oe_o(bus_oe), .bus_pull_low_o(pull_low), .display_power_o(d_pow), .display_drive_o(d_drv),
    .display_lines_high_o(d_high), .tick512_o(tick), .timer_wake_o(twake), .interrupt_line_n_o(int_n),
    .time_count_o(tcount));
  pss_cpu_model cpu (.clock_i(clock_i), .sleep_on_i(sleep_on), .cpu_run_i(cpu_run), .halt_o(halt),
    .ref_clock_o(ref_clock));

  initial begin
    forever #50 clock_i = ~clock_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic give_verdict;
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic wait_state(input logic [1:0] s, input int lim);
    tw_seen = 1'b0;
    for (n = 0; n < lim && state !== s; n++) begin
      @(negedge clock_i);
      tw_seen |= (twake === 1'b1);
    end
    if (state !== s) begin
      chk(1'b0, "state wait timed out");
      give_verdict();
    end
  endtask

  // Sleep pin levels; display only differs in deep
  task automatic chk_sleep(input logic deep);
    chk(cpu_run === 1'b0 && strobe === 1'b1 && strobe_oe === 1'b0 && cd_oe === 1'b0 && bus_q === BUS_LOW
      && pull_low === 1'b1 && d_pow === !deep && d_drv === !deep && d_high === deep, "sleep outputs");
  endtask

  initial begin
    #(100 * 90000);
    chk(1'b0, "global timeout");
    give_verdict();
  end

  initial begin
    repeat (2) @(negedge clock_i);
    resetn_i = 1'b1;
    chk(state === PSS_AWAKE && cpu_run === 1'b1 && strobe === 1'b1 && tcount === '0 && int_n === 1'b1, "reset");
    for (i = 0; i < 40 && strobe !== 1'b0; i++) @(negedge clock_i);
    for (n = 0; n < 40 && strobe === 1'b0; n++) @(negedge clock_i);
    chk(n == STROBE_HALF, "strobe half period");
    for (i = 0; i < 24; i++) begin
      seed = xs(seed);
      bus_d = seed[3:0];
      cd = seed[4];
      @(negedge clock_i);
      chk(bus_q === seed[3:0] && cd_line === seed[4] && cd_oe === 1'b1 && d_pow === 1'b1, "awake pass");
    end
    tick_prev = tick;
    for (i = 0; i < 600 && tick === tick_prev; i++) @(negedge clock_i);
    t0 = tcount;
    tick_prev = tick;
    for (n = 1; n < 600; n++) begin
      @(negedge clock_i);
      if (tick !== tick_prev) break;
    end
    chk(n == TC && tcount === t0 + 1, "tick period");
    sleep_on = 1'b1;
    wait_state(PSS_LIGHT, 20);
    t0 = tcount;
    chk(bus_oe === 1'b1, "bus precharge");
    chk_sleep(1'b0);
    @(negedge clock_i);
    chk(bus_oe === 1'b0 && pull_low === 1'b1, "bus released");
    wait_state(PSS_AWAKE, HT * TC + 8);
    chk(n >= (HT - 1) * TC && tw_seen, "light timer wake");
    wait_state(PSS_DEEP, (IT + 1) * TC);
    chk(tcount - t0 >= IT - 1 && tcount - t0 <= IT + 1, "idle timeout");
    chk_sleep(1'b1);
    wait_state(PSS_AWAKE, MT * TC + 8);
    chk(n >= (MT - 1) * TC && tw_seen, "deep timer wake");
    wait_state(PSS_DEEP, 20);
    chk(tcount - t0 >= IT + MT - 2, "time kept across states");
    pkey = 1'b1;
    @(negedge clock_i);
    pkey = 1'b0;
    chk(state === PSS_LIGHT, "power key from deep");
    pkey = 1'b1;
    @(negedge clock_i);
    pkey = 1'b0;
    chk(state === PSS_LIGHT, "power key ignored in light");
    for (i = 0; i < 3; i++) begin
      {key, intr, alarm} = 3'b100 >> i;
      @(negedge clock_i);
      {key, intr, alarm} = 3'b000;
      chk(state === PSS_AWAKE, "wake source");
      wait_state(PSS_LIGHT, 20);
    end
    wait_state(PSS_DEEP, (IT + 2) * TC);
    modc = 1'b1;
    @(negedge clock_i);
    modc = 1'b0;
    chk(state === PSS_AWAKE, "module change wakes");
    for (i = 0; i < 3 && int_n !== 1'b0; i++) @(negedge clock_i);
    for (n = 0; n < 10 && int_n === 1'b0; n++) @(negedge clock_i);
    chk(n == INT_PULSE_CYCLES, "interrupt line pulse");
    sleep_on = 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
